// file: verilog/occ_pkg.sv
// Package for the cascaded output compare pair: widths, reset values,
// bit positions and shared carrier structs.
// Assumes a single clock domain; all users import occ_pkg::*.
package occ_pkg;
  localparam int OCC_HALF_W = 16;
  localparam int OCC_FULL_W = 32;
  localparam int OCC_CASCADE_BIT = 8;
  localparam int OCC_CTRL2_W = 16;
  localparam logic [15:0] OCC_CNT_RST = 16'h0000;
  localparam logic [15:0] OCC_CNT_MAX = 16'hffff;
  localparam logic [15:0] OCC_CMP_RST = 16'h0000;

  // Settings software places on one module
  typedef struct packed {
    logic [15:0] compare_control_two;
    logic [15:0] primary_compare_value;
    logic [15:0] secondary_compare_value;
  } occ_cfg_t;

  // Per-module count and status
  typedef struct packed {
    logic [15:0] compare_counter;
    logic primary_match;
    logic secondary_match;
    logic wrap;
  } occ_stat_t;
endpackage

// file: verilog/occ_half.sv
// One 16-bit counter half with its wrap flag; it holds no compare values.
// Assumes the parent decides when it counts and what it compares.
`timescale 1ns/1ps
module occ_half (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Control
  input wire logic count_en_in,
  // State
  output logic [15:0] count_out,
  output logic wrap_out
);
  import occ_pkg::*;
  logic [15:0] next_count;

  always_comb begin
    next_count = count_en_in ? count_out + 16'h0001 : count_out;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= OCC_CNT_RST;
    end else begin
      count_out <= next_count;
    end
  end

  // Wrap is seen while the counter is about to roll 0xffff to 0x0000
  assign wrap_out = count_en_in && (count_out == OCC_CNT_MAX);
endmodule

// file: verilog/occ_pair.sv
// Pair of adjacent 16-bit output compare modules, optionally cascaded
// into one 32-bit compare timer.
// Assumes the tick inputs are on mclk_in (from the clock selector) and
// that settings come from same-clock control logic.
// Overview of operation
// - Without cascading each module counts and compares on its own.
// - Only the fixed odd/even pair here may be joined into 32 bits.
// - Odd module holds the low 16 bits of counter and compares.
// - Even module holds the high 16 bits of counter and compares.
// - Low counter wrap increments the high counter by one.
// - Cascade active only when bit 8 set in both control words.
// - Free-running counters count up and roll from 0xffff to zero.
// - Event whenever counter equals either compare value.
`timescale 1ns/1ps
module occ_pair (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Per-module count ticks
  input wire logic odd_tick_in,
  input wire logic even_tick_in,
  // Settings
  input wire occ_pkg::occ_cfg_t odd_cfg_in,
  input wire occ_pkg::occ_cfg_t even_cfg_in,
  // Status
  output occ_pkg::occ_stat_t odd_stat_out,
  output occ_pkg::occ_stat_t even_stat_out,
  output logic cascade_out,
  // Events
  output logic odd_event_out,
  output logic even_event_out,
  output logic pair_event_out
);
  import occ_pkg::*;

  logic cascade_enable;
  logic odd_wrap;
  logic even_wrap;
  logic even_step;
  logic [15:0] odd_cnt;
  logic [15:0] even_cnt;
  logic [31:0] pair_cnt;
  logic [31:0] pair_pri;
  logic [31:0] pair_sec;
  occ_stat_t next_odd_stat;
  occ_stat_t next_even_stat;
  logic next_cascade;
  logic next_odd_event;
  logic next_even_event;
  logic next_pair_event;

  // Both modules must agree, so one stray bit never half-joins the pair
  assign cascade_enable = odd_cfg_in.compare_control_two[OCC_CASCADE_BIT]
    && even_cfg_in.compare_control_two[OCC_CASCADE_BIT];

  // High half steps on the low half's wrap when joined
  assign even_step = cascade_enable ? odd_wrap : even_tick_in;

  occ_half u_low_half_module (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .count_en_in(odd_tick_in),
    .count_out(odd_cnt),
    .wrap_out(odd_wrap)
  );

  occ_half u_high_half_module (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .count_en_in(even_step),
    .count_out(even_cnt),
    .wrap_out(even_wrap)
  );

  // Fixed pairing: even above odd, no other combination exists
  assign pair_cnt = {even_cnt, odd_cnt};
  assign pair_pri = {even_cfg_in.primary_compare_value,
    odd_cfg_in.primary_compare_value};
  assign pair_sec = {even_cfg_in.secondary_compare_value,
    odd_cfg_in.secondary_compare_value};

  always_comb begin
    next_cascade = cascade_enable;
    next_odd_stat.compare_counter = odd_cnt;
    next_odd_stat.primary_match =
      odd_cnt == odd_cfg_in.primary_compare_value;
    next_odd_stat.secondary_match =
      odd_cnt == odd_cfg_in.secondary_compare_value;
    next_odd_stat.wrap = odd_wrap;
    next_even_stat.compare_counter = even_cnt;
    next_even_stat.primary_match =
      even_cnt == even_cfg_in.primary_compare_value;
    next_even_stat.secondary_match =
      even_cnt == even_cfg_in.secondary_compare_value;
    next_even_stat.wrap = even_wrap;
    // Joined pair compares 32 bits; halves stop reporting alone
    next_pair_event = cascade_enable &&
      (pair_cnt == pair_pri || pair_cnt == pair_sec);
    next_odd_event = !cascade_enable && (next_odd_stat.primary_match ||
      next_odd_stat.secondary_match);
    next_even_event = !cascade_enable && (next_even_stat.primary_match ||
      next_even_stat.secondary_match);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      odd_stat_out <= '0;
      even_stat_out <= '0;
      cascade_out <= 1'b0;
      odd_event_out <= 1'b0;
      even_event_out <= 1'b0;
      pair_event_out <= 1'b0;
    end else begin
      odd_stat_out <= next_odd_stat;
      even_stat_out <= next_even_stat;
      cascade_out <= next_cascade;
      odd_event_out <= next_odd_event;
      even_event_out <= next_even_event;
      pair_event_out <= next_pair_event;
    end
  end

  // Carry is one step: the low half rolls and the high half moves by one on the same edge
  sequence low_wrap_s;
    cascade_enable && odd_wrap;
  endsequence

  sequence high_step_s;
    even_cnt == $past(even_cnt) + 16'h0001;
  endsequence

  property carry_step_p;
    @(posedge mclk_in) disable iff (rst_in)
    low_wrap_s |=> high_step_s;
  endproperty
  carry_into_high_a: assert property (carry_step_p)
    else $error("high half missed carry");

  high_hold_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (cascade_enable && !odd_wrap) |=> $stable(even_cnt))
    else $error("high half moved without carry");

  low_roll_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (odd_tick_in && odd_cnt == OCC_CNT_MAX) |=> odd_cnt == OCC_CNT_RST)
    else $error("low half did not roll over");

  low_count_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (odd_tick_in && odd_cnt != OCC_CNT_MAX) |=>
      odd_cnt == $past(odd_cnt) + 16'h0001)
    else $error("low half did not count");

  indep_high_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (!cascade_enable && !even_tick_in) |=> $stable(even_cnt))
    else $error("independent high half moved");

  pair_event_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (cascade_enable && pair_cnt == pair_pri) |=> pair_event_out)
    else $error("pair match event missing");

  odd_event_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (!cascade_enable && odd_cnt == odd_cfg_in.secondary_compare_value)
      |=> odd_event_out && !pair_event_out)
    else $error("odd event wrong");

  join_flag_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !$past(rst_in) |-> cascade_out ==
      $past(odd_cfg_in.compare_control_two[OCC_CASCADE_BIT]
      && even_cfg_in.compare_control_two[OCC_CASCADE_BIT]))
    else $error("cascade flag wrong");

  word_order_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    1'b1 |=> {even_stat_out.compare_counter, odd_stat_out.compare_counter}
      == $past(pair_cnt))
    else $error("half order wrong");

  // Independent high half counts its own ticks
  high_count_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (!cascade_enable && even_tick_in && even_cnt != OCC_CNT_MAX) |=>
      even_cnt == $past(even_cnt) + 16'h0001)
    else $error("independent high half did not count");

  high_roll_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (!cascade_enable && even_tick_in && even_cnt == OCC_CNT_MAX) |=>
      even_cnt == OCC_CNT_RST)
    else $error("high half did not roll over");

  low_hold_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !odd_tick_in |=> $stable(odd_cnt))
    else $error("low half moved without a tick");

  // The joined pair reports only through the 32-bit event
  joined_quiet_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    cascade_enable |=> !odd_event_out && !even_event_out)
    else $error("half event while joined");

  solo_pair_quiet_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !cascade_enable |=> !pair_event_out)
    else $error("pair event while not joined");

  even_event_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (!cascade_enable && even_cnt == even_cfg_in.primary_compare_value)
      |=> even_event_out)
    else $error("even match event missing");

  pair_sec_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (cascade_enable && pair_cnt == pair_sec) |=> pair_event_out)
    else $error("pair secondary event missing");

  // Wrap status is registered from odd_wrap, so it shows on the same edge the low half rolls
  wrap_flag_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    low_wrap_s |=> odd_stat_out.wrap)
    else $error("low wrap not reported");
endmodule

// file: tb/occ_pair_tb.sv
// Self-checking bench for the cascaded compare pair.
// Assumes the pair's assertions cover timing; this checks results.
`timescale 1ns/1ps
module output_compare_cascade_32bit_tb;
  import occ_pkg::*;
  logic mclk_in = 1'b0, rst_in = 1'b1;
  logic odd_tick = 1'b0, even_tick = 1'b0;
  occ_cfg_t odd_cfg = '0, even_cfg = '0;
  occ_stat_t odd_stat, even_stat;
  logic cascade, odd_ev, even_ev, pair_ev;
  int n_mismatch = 0, tests_run = 0;
  occ_pair occ_pair_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .odd_tick_in(odd_tick),
    .even_tick_in(even_tick), .odd_cfg_in(odd_cfg), .even_cfg_in(even_cfg),
    .odd_stat_out(odd_stat), .even_stat_out(even_stat), .cascade_out(cascade),
    .odd_event_out(odd_ev), .even_event_out(even_ev), .pair_event_out(pair_ev)
  );
  initial forever #12.5 mclk_in = ~mclk_in;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // n ticks, then idle while the registered outputs settle
  task ticks(input logic o, input logic e, input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge mclk_in);
      odd_tick <= o && i < n;
      even_tick <= e && i < n;
    end
    repeat (3) @(posedge mclk_in);
    #1;
  endtask
  task test_solo;
    @(posedge mclk_in);
    odd_cfg <= '{16'h0000, 16'h0005, 16'h0009};
    even_cfg <= '{16'h0000, 16'h0003, 16'h0007};
    ticks(1'b1, 1'b0, 5);
    ticks(1'b0, 1'b1, 3);
    check(odd_stat.compare_counter, 32'h5);
    check(even_stat.compare_counter, 32'h3);
    check(odd_stat.primary_match, 32'h1);
    check(even_stat.primary_match, 32'h1);
    check(odd_ev, 32'h1);
    check(even_ev, 32'h1);
    check(pair_ev, 32'h0);
    check(cascade, 32'h0);
    ticks(1'b1, 1'b0, 4);
    check(odd_stat.primary_match, 32'h0);
    check(odd_stat.secondary_match, 32'h1);
    check(odd_ev, 32'h1);
  endtask
  task test_one_bit;
    @(posedge mclk_in);
    odd_cfg.compare_control_two[OCC_CASCADE_BIT] <= 1'b1;
    ticks(1'b0, 1'b1, 1);
    check(cascade, 32'h0);
    check(even_stat.compare_counter, 32'h4);
    check(even_ev, 32'h0);
  endtask
  // Long run: the counters cannot be loaded near the wrap
  task test_cascade;
    @(posedge mclk_in);
    odd_cfg <= '{16'h0100, 16'h0001, 16'h0009};
    even_cfg <= '{16'h0100, 16'h0005, 16'h0007};
    ticks(1'b0, 1'b1, 2);
    check(cascade, 32'h1);
    check(even_stat.compare_counter, 32'h4);
    check(odd_ev, 32'h0);
    ticks(1'b1, 1'b0, 65526);
    check(odd_stat.compare_counter, 32'hffff);
    check(even_stat.compare_counter, 32'h4);
    @(posedge mclk_in);
    odd_tick <= 1'b1;
    @(posedge mclk_in);
    odd_tick <= 1'b0;
    #1;
    check(odd_stat.wrap, 32'h1);
    repeat (3) @(posedge mclk_in);
    #1;
    check(odd_stat.compare_counter, 32'h0);
    check(even_stat.compare_counter, 32'h5);
    check(pair_ev, 32'h0);
    ticks(1'b1, 1'b0, 1);
    check(pair_ev, 32'h1);
    check(odd_ev, 32'h0);
    check(even_ev, 32'h0);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    test_solo;
    test_one_bit;
    test_cascade;
    end_sim;
  end
endmodule
